/* hw/csr_pkg.sv */
package csr_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int REGS_PER_BANK = 8;
    localparam int BANKS_SMALL = 16;
    localparam int BANKS_LARGE = 32;
    localparam int RAM_BYTES_DEFAULT = 1024;
    localparam logic [15:0] BANK_BASE_DEFAULT = 16'h0100;
    localparam logic [15:0] IO_TOP_DEFAULT = 16'h007f;

    // Register port offsets
    localparam logic [3:0] ADDR_IP = 4'h0;
    localparam logic [3:0] ADDR_ACC = 4'h1;
    localparam logic [3:0] ADDR_TMP = 4'h2;
    localparam logic [3:0] ADDR_IDX = 4'h3;
    localparam logic [3:0] ADDR_EXP = 4'h4;
    localparam logic [3:0] ADDR_STK = 4'h5;
    localparam logic [3:0] ADDR_PSW = 4'h6;
    localparam logic [3:0] ADDR_BANK_ADDR = 4'h7;
    localparam logic [3:0] ADDR_ID = 4'h8;
    localparam logic [15:0] ID_VALUE = 16'h5a3c;

    // Condition code bit positions
    localparam int CC_H = 7;
    localparam int CC_I = 6;
    localparam int CC_IL_HI = 5;
    localparam int CC_IL_LO = 4;
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_V = 1;
    localparam int CC_C = 0;
    localparam logic [7:0] CC_RESET = 8'h30;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [1:0] IL_NONE = 2'h3;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD8 = 4'h1,
        OP_SUB8 = 4'h2,
        OP_ADDC8 = 4'h3,
        OP_SUBC8 = 4'h4,
        OP_AND8 = 4'h5,
        OP_OR8 = 4'h6,
        OP_XOR8 = 4'h7,
        OP_SHL8 = 4'h8,
        OP_SHR8 = 4'h9,
        OP_ADD16 = 4'ha,
        OP_SUB16 = 4'hb,
        OP_MOV_A = 4'hc,
        OP_MOV_AT = 4'hd
    } csr_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } csr_state_t;

    typedef struct packed {
        csr_state_t state;
        logic [15:0] instr_pointer;
        logic [15:0] acc;
        logic [15:0] tmp_acc;
        logic [15:0] index_register;
        logic [15:0] extra_pointer;
        logic [15:0] stack_pointer;
        logic [7:0] register_bank_pointer;
        logic [7:0] condition_code_byte;
        logic [15:0] rd_data;
        logic int_accept;
    } csr_state_s_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } csr_bus_t;

    typedef struct packed {
        logic valid;
        csr_op_t op;
    } csr_alu_req_t;
endpackage : csr_pkg

/* hw/csr_core.sv */
`timescale 1ns/10ps
module csr_core #(
    parameter int RAM_BYTES = csr_pkg::RAM_BYTES_DEFAULT,
    parameter logic [15:0] BANK_BASE = csr_pkg::BANK_BASE_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire csr_pkg::csr_bus_t i_bus,
    output logic [15:0] o_rdata,
    input wire csr_pkg::csr_alu_req_t i_alu,
    input wire logic i_ip_load,
    input wire logic [15:0] i_ip_value,
    input wire logic i_ip_step,
    input wire logic [2:0] i_gpr_sel,
    input wire logic i_int_req,
    input wire logic [1:0] i_int_level,
    output logic o_int_accept,
    output logic [15:0] o_gpr_addr,
    output logic o_gpr_addr_valid,
    output logic [15:0] o_status_word
);
    import csr_pkg::*;

    localparam int BANK_COUNT = (RAM_BYTES <= 256) ? BANKS_SMALL : BANKS_LARGE;

    csr_state_s_t st_reg;
    csr_state_s_t st_next;

    logic [8:0] sum8;
    logic [4:0] nib;
    logic [16:0] sum16;
    logic [7:0] a8;
    logic [7:0] t8;
    logic [7:0] r8;
    logic cin;
    logic [15:0] bank_addr;
    logic bank_ok;
    logic [15:0] rd_val;

    // Bank base is bank times eight above the RAM offset
    assign bank_addr = BANK_BASE + {8'h00, st_reg.register_bank_pointer[4:0], 3'h0}
        + {13'h0000, i_gpr_sel};
    // Banks beyond the RAM size are flagged; the address still wraps on pointer bits 4:0
    assign bank_ok = ({24'h000000, st_reg.register_bank_pointer} < BANK_COUNT);

    always_comb begin
        rd_val = 16'h0000;
        if (i_bus.addr == ADDR_IP) begin
            rd_val = st_reg.instr_pointer;
        end else if (i_bus.addr == ADDR_ACC) begin
            rd_val = st_reg.acc;
        end else if (i_bus.addr == ADDR_TMP) begin
            rd_val = st_reg.tmp_acc;
        end else if (i_bus.addr == ADDR_IDX) begin
            rd_val = st_reg.index_register;
        end else if (i_bus.addr == ADDR_EXP) begin
            rd_val = st_reg.extra_pointer;
        end else if (i_bus.addr == ADDR_STK) begin
            rd_val = st_reg.stack_pointer;
        end else if (i_bus.addr == ADDR_PSW) begin
            rd_val = {st_reg.register_bank_pointer, st_reg.condition_code_byte};
        end else if (i_bus.addr == ADDR_BANK_ADDR) begin
            rd_val = bank_addr;
        end else if (i_bus.addr == ADDR_ID) begin
            rd_val = ID_VALUE;
        end
    end

    always_comb begin
        st_next = st_reg;
        a8 = st_reg.acc[7:0];
        t8 = st_reg.tmp_acc[7:0];
        cin = st_reg.condition_code_byte[CC_C];
        sum8 = 9'h000;
        nib = 5'h00;
        sum16 = 17'h00000;
        r8 = 8'h00;
        st_next.int_accept = 1'b0;
        if (i_bus.rd) begin
            st_next.rd_data = rd_val;
        end
        if (i_ip_load) begin
            st_next.instr_pointer = i_ip_value;
        end else if (i_ip_step) begin
            st_next.instr_pointer = st_reg.instr_pointer + 16'h0001;
        end
        // Accept only strictly more urgent requests; lower code is more urgent
        if (i_int_req && st_reg.condition_code_byte[CC_I]
            && st_reg.condition_code_byte[CC_IL_HI:CC_IL_LO] != IL_NONE
            && i_int_level < st_reg.condition_code_byte[CC_IL_HI:CC_IL_LO]) begin
            st_next.int_accept = 1'b1;
        end
        case (st_reg.state)
            ST_IDLE: begin
                if (i_alu.valid) begin
                    st_next.state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                st_next.state = ST_IDLE;
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
        if (i_alu.valid) begin
            case (i_alu.op)
                OP_ADD8, OP_ADDC8: begin
                    sum8 = {1'b0, a8} + {1'b0, t8} + {8'h00, (i_alu.op == OP_ADDC8) & cin};
                    nib = {1'b0, a8[3:0]} + {1'b0, t8[3:0]} + {4'h0, (i_alu.op == OP_ADDC8) & cin};
                    r8 = sum8[7:0];
                    st_next.acc = {st_reg.acc[15:8], r8};
                    st_next.condition_code_byte[CC_H] = nib[4];
                    st_next.condition_code_byte[CC_C] = sum8[8];
                    st_next.condition_code_byte[CC_V] = (a8[7] == t8[7]) && (r8[7] != a8[7]);
                    st_next.condition_code_byte[CC_N] = r8[7];
                    st_next.condition_code_byte[CC_Z] = (r8 == 8'h00);
                end
                OP_SUB8, OP_SUBC8: begin
                    sum8 = {1'b0, a8} - {1'b0, t8} - {8'h00, (i_alu.op == OP_SUBC8) & cin};
                    nib = {1'b0, a8[3:0]} - {1'b0, t8[3:0]} - {4'h0, (i_alu.op == OP_SUBC8) & cin};
                    r8 = sum8[7:0];
                    st_next.acc = {st_reg.acc[15:8], r8};
                    st_next.condition_code_byte[CC_H] = nib[4];
                    st_next.condition_code_byte[CC_C] = sum8[8];
                    st_next.condition_code_byte[CC_V] = (a8[7] != t8[7]) && (r8[7] != a8[7]);
                    st_next.condition_code_byte[CC_N] = r8[7];
                    st_next.condition_code_byte[CC_Z] = (r8 == 8'h00);
                end
                OP_AND8, OP_OR8, OP_XOR8: begin
                    r8 = (i_alu.op == OP_AND8) ? (a8 & t8) : ((i_alu.op == OP_OR8) ? (a8 | t8) : (a8 ^ t8));
                    st_next.acc = {st_reg.acc[15:8], r8};
                    st_next.condition_code_byte[CC_V] = 1'b0;
                    st_next.condition_code_byte[CC_N] = r8[7];
                    st_next.condition_code_byte[CC_Z] = (r8 == 8'h00);
                end
                OP_SHL8: begin
                    r8 = {a8[6:0], 1'b0};
                    st_next.acc = {st_reg.acc[15:8], r8};
                    st_next.condition_code_byte[CC_C] = a8[7];
                    st_next.condition_code_byte[CC_N] = r8[7];
                    st_next.condition_code_byte[CC_Z] = (r8 == 8'h00);
                end
                OP_SHR8: begin
                    r8 = {1'b0, a8[7:1]};
                    st_next.acc = {st_reg.acc[15:8], r8};
                    st_next.condition_code_byte[CC_C] = a8[0];
                    st_next.condition_code_byte[CC_N] = r8[7];
                    st_next.condition_code_byte[CC_Z] = (r8 == 8'h00);
                end
                OP_ADD16, OP_SUB16: begin
                    // Word forms report flags on the full 16-bit result
                    if (i_alu.op == OP_ADD16) begin
                        sum16 = {1'b0, st_reg.acc} + {1'b0, st_reg.tmp_acc};
                        st_next.condition_code_byte[CC_V] = (st_reg.acc[15] == st_reg.tmp_acc[15])
                            && (sum16[15] != st_reg.acc[15]);
                    end else begin
                        sum16 = {1'b0, st_reg.acc} - {1'b0, st_reg.tmp_acc};
                        st_next.condition_code_byte[CC_V] = (st_reg.acc[15] != st_reg.tmp_acc[15])
                            && (sum16[15] != st_reg.acc[15]);
                    end
                    st_next.acc = sum16[15:0];
                    st_next.condition_code_byte[CC_C] = sum16[16];
                    st_next.condition_code_byte[CC_N] = sum16[15];
                    st_next.condition_code_byte[CC_Z] = (sum16[15:0] == 16'h0000);
                end
                OP_MOV_AT: begin
                    st_next.tmp_acc = st_reg.acc;
                end
                default: begin
                    st_next.condition_code_byte = st_reg.condition_code_byte;
                end
            endcase
        end
        // Software writes land last so they win over a same-cycle operation
        if (i_bus.wr) begin
            if (i_bus.addr == ADDR_IP) begin
                st_next.instr_pointer = i_bus.wdata;
            end else if (i_bus.addr == ADDR_ACC) begin
                st_next.acc = i_bus.wdata;
            end else if (i_bus.addr == ADDR_TMP) begin
                st_next.tmp_acc = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IDX) begin
                st_next.index_register = i_bus.wdata;
            end else if (i_bus.addr == ADDR_EXP) begin
                st_next.extra_pointer = i_bus.wdata;
            end else if (i_bus.addr == ADDR_STK) begin
                st_next.stack_pointer = i_bus.wdata;
            end else if (i_bus.addr == ADDR_PSW) begin
                st_next.register_bank_pointer = i_bus.wdata[15:8];
                st_next.condition_code_byte = i_bus.wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_reg <= '{state: ST_IDLE, instr_pointer: 16'h0000, acc: 16'h0000, tmp_acc: 16'h0000,
                index_register: 16'h0000, extra_pointer: 16'h0000, stack_pointer: 16'h0000,
                register_bank_pointer: BANK_RESET, condition_code_byte: CC_RESET,
                rd_data: 16'h0000, int_accept: 1'b0};
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rd_data;
    assign o_int_accept = st_reg.int_accept;
    assign o_gpr_addr = bank_addr;
    assign o_gpr_addr_valid = bank_ok;
    assign o_status_word = {st_reg.register_bank_pointer, st_reg.condition_code_byte};
endmodule : csr_core

/* testbench/csr_core_checker.sv */
`timescale 1ns/10ps
module csr_core_checker #(
    parameter int RAM_BYTES = 1024,
    parameter logic [15:0] BANK_BASE = 16'h0100
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire csr_pkg::csr_bus_t i_bus,
    input wire logic [15:0] o_rdata,
    input wire csr_pkg::csr_alu_req_t i_alu,
    input wire logic i_ip_load,
    input wire logic [15:0] i_ip_value,
    input wire logic i_ip_step,
    input wire logic [2:0] i_gpr_sel,
    input wire logic i_int_req,
    input wire logic [1:0] i_int_level,
    input wire logic o_int_accept,
    input wire logic [15:0] o_gpr_addr,
    input wire logic o_gpr_addr_valid,
    input wire logic [15:0] o_status_word
);
    import csr_pkg::*;
    logic [7:0] cc;
    logic [7:0] bank;
    logic hit;
    logic rd_go;
    assign cc = o_status_word[7:0];
    assign bank = o_status_word[15:8];
    // Code 3 must admit nothing even though levels 0 to 2 compare below it
    assign hit = i_int_req && cc[CC_I] && cc[5:4] != IL_NONE && i_int_level < cc[5:4];
    assign rd_go = i_clk_en && i_bus.rd;
    default clocking dc @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    reset_state_a: assert property ($past(i_sys_rst)
        |-> o_status_word == {BANK_RESET, CC_RESET} && !o_int_accept) else $error("state after reset wrong");
    accept_when_a: assert property (i_clk_en && hit |=> o_int_accept)
        else $error("qualifying interrupt not accepted");
    no_accept_a: assert property (i_clk_en && !hit |=> !o_int_accept)
        else $error("interrupt accepted without qualifying");
    bank_addr_a: assert property (o_gpr_addr == BANK_BASE + {8'h00, bank[4:0], 3'h0} + {13'h0, i_gpr_sel})
        else $error("register address does not follow bank pointer");
    bank_count_a: assert property (o_gpr_addr_valid == (bank < ((RAM_BYTES <= 256) ? BANKS_SMALL : BANKS_LARGE)))
        else $error("bank valid flag wrong");
    psw_read_a: assert property (rd_go && i_bus.addr == ADDR_PSW |=> o_rdata == $past(o_status_word))
        else $error("status word read mismatch");
    rdata_hold_a: assert property (!rd_go |=> $stable(o_rdata))
        else $error("read data moved without a read");
    flags_hold_a: assert property ((!i_clk_en || !(i_alu.valid || i_bus.wr)) |=> $stable(o_status_word))
        else $error("status word changed without cause");
    cover property (o_int_accept);
    cover property (i_clk_en && i_alu.valid);
    cover property (!o_gpr_addr_valid);
    cover property (rd_go && i_bus.addr == ADDR_PSW);
endmodule : csr_core_checker

bind csr_core csr_core_checker #(.RAM_BYTES(RAM_BYTES), .BANK_BASE(BANK_BASE)) i_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_alu(i_alu), .i_ip_load(i_ip_load), .i_ip_value(i_ip_value), .i_ip_step(i_ip_step),
    .i_gpr_sel(i_gpr_sel), .i_int_req(i_int_req), .i_int_level(i_int_level), .o_int_accept(o_int_accept),
    .o_gpr_addr(o_gpr_addr), .o_gpr_addr_valid(o_gpr_addr_valid), .o_status_word(o_status_word));

/* testbench/cpu_status_and_register_banks_test.sv */
`timescale 1ns/10ps
module cpu_status_and_register_banks_test;
    import csr_pkg::*;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_clk_en = 1'b1;
    csr_bus_t i_bus = '0;
    csr_alu_req_t i_alu = '0;
    logic i_ip_load = 1'b0;
    logic i_ip_step = 1'b0;
    logic [15:0] i_ip_value = 16'h0;
    logic [2:0] i_gpr_sel = 3'h0;
    logic i_int_req = 1'b0;
    logic [1:0] i_int_level = 2'h0;
    logic [15:0] o_rdata, o_gpr_addr, o_status_word;
    logic o_int_accept, o_gpr_addr_valid;
    int bad_count = 0;
    int comparisons = 0;
    logic [15:0] notes[$];
    logic rd_pend = 1'b0;
    logic [15:0] acc, tmp, exp_acc, exp_tmp;
    logic [7:0] cc, exp_cc, bank;
    csr_op_t ops[12] = '{OP_ADD8, OP_SUB8, OP_ADDC8, OP_SUBC8, OP_AND8, OP_OR8, OP_XOR8, OP_SHL8, OP_SHR8,
        OP_ADD16, OP_SUB16, OP_MOV_AT};

    csr_core #(.RAM_BYTES(256)) i_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_bus(i_bus), .o_rdata(o_rdata), .i_alu(i_alu), .i_ip_load(i_ip_load), .i_ip_value(i_ip_value),
        .i_ip_step(i_ip_step), .i_gpr_sel(i_gpr_sel), .i_int_req(i_int_req), .i_int_level(i_int_level),
        .o_int_accept(o_int_accept), .o_gpr_addr(o_gpr_addr), .o_gpr_addr_valid(o_gpr_addr_valid),
        .o_status_word(o_status_word));

    initial begin
        forever #50 i_clock = ~i_clock;
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : check16

    task automatic wrap_up();
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // Read data is compared in the cycle after the strobe and holds until the next read
    always @(posedge i_clock) begin
        if (rd_pend) check16(o_rdata, notes.pop_front());
        rd_pend <= i_bus.rd && i_clk_en && !i_sys_rst;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_bus <= '{a, d, 1'b1, 1'b0};
        i_alu <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] want);
        @(posedge i_clock);
        i_bus <= '{a, 16'h0, 1'b0, 1'b1};
        i_alu <= '0;
        notes.push_back(want);
    endtask : rd

    task automatic ip(input logic ld, input logic st, input logic [15:0] v);
        @(posedge i_clock);
        i_bus <= '0;
        i_ip_load <= ld;
        i_ip_step <= st;
        i_ip_value <= v;
    endtask : ip

    task automatic alu(input csr_op_t op);
        @(posedge i_clock);
        i_bus <= '0;
        i_alu <= '{1'b1, op};
    endtask : alu

    function automatic void model(input csr_op_t op);
        logic [8:0] r;
        logic [4:0] h;
        logic ci;
        logic [16:0] w;
        h = 5'h0;
        ci = (op == OP_ADDC8 || op == OP_SUBC8) ? cc[CC_C] : 1'b0;
        exp_cc = cc;
        case (op)
            OP_ADD8, OP_ADDC8: begin
                r = acc[7:0] + tmp[7:0] + ci;
                h = acc[3:0] + tmp[3:0] + ci;
                exp_cc[CC_V] = (acc[7] == tmp[7]) && (r[7] != acc[7]);
            end
            OP_SUB8, OP_SUBC8: begin
                r = acc[7:0] - tmp[7:0] - ci;
                h = acc[3:0] - tmp[3:0] - ci;
                exp_cc[CC_V] = (acc[7] != tmp[7]) && (r[7] != acc[7]);
            end
            OP_AND8: r = {cc[CC_C], acc[7:0] & tmp[7:0]};
            OP_OR8: r = {cc[CC_C], acc[7:0] | tmp[7:0]};
            OP_XOR8: r = {cc[CC_C], acc[7:0] ^ tmp[7:0]};
            OP_SHL8: r = {acc[7:0], 1'b0};
            default: r = {acc[0], 1'b0, acc[7:1]};
        endcase
        if (op inside {OP_ADD8, OP_ADDC8, OP_SUB8, OP_SUBC8}) exp_cc[CC_H] = h[4];
        if (op inside {OP_AND8, OP_OR8, OP_XOR8}) exp_cc[CC_V] = 1'b0;
        exp_cc[CC_C] = r[8];
        exp_cc[CC_N] = r[7];
        exp_cc[CC_Z] = (r[7:0] == 8'h00);
        exp_acc = {acc[15:8], r[7:0]};
        // Word forms and the move override the byte results above
        exp_tmp = (op == OP_MOV_AT) ? acc : tmp;
        w = (op == OP_SUB16) ? ({1'b0, acc} - {1'b0, tmp}) : ({1'b0, acc} + {1'b0, tmp});
        if (op inside {OP_ADD16, OP_SUB16}) begin
            exp_cc[CC_C] = w[16];
            exp_cc[CC_N] = w[15];
            exp_cc[CC_Z] = (w[15:0] == 16'h0000);
            exp_cc[CC_V] = (w[15] != acc[15]) && ((acc[15] == tmp[15]) == (op == OP_ADD16));
            exp_acc = w[15:0];
        end
        if (op == OP_MOV_AT) begin
            exp_cc = cc;
            exp_acc = acc;
        end
    endfunction : model

    initial begin
        repeat (5000) @(posedge i_clock);
        bad_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h2030e1fe));
        repeat (20) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(a[3:0], 16'h0);
        rd(ADDR_PSW, 16'h0030);
        for (int a = 0; a < 6; a++) begin
            acc = 16'($urandom);
            wr(a[3:0], acc);
            rd(a[3:0], acc);
        end
        // Read-only and unmapped places must not take writes
        wr(ADDR_ID, 16'hffff);
        wr(4'hc, 16'h1234);
        rd(ADDR_ID, ID_VALUE);
        rd(4'hc, 16'h0);
        wr(ADDR_IP, 16'hffff);
        ip(1'b0, 1'b1, 16'h0);
        ip(1'b0, 1'b0, 16'h0);
        rd(ADDR_IP, 16'h0000);
        ip(1'b1, 1'b1, 16'h1234);
        ip(1'b0, 1'b0, 16'h0);
        rd(ADDR_IP, 16'h1234);
        for (int i = 0; i < 96; i++) begin
            acc = 16'($urandom);
            tmp = (i % 3 == 0) ? acc : 16'($urandom);
            cc = 8'($urandom);
            bank = 8'($urandom_range(0, 31));
            wr(ADDR_ACC, acc);
            wr(ADDR_TMP, tmp);
            wr(ADDR_PSW, {bank, cc});
            i_gpr_sel <= 3'($urandom);
            i_int_req <= 1'($urandom);
            i_int_level <= 2'($urandom);
            alu(ops[i % 12]);
            model(ops[i % 12]);
            rd(ADDR_ACC, exp_acc);
            rd(ADDR_TMP, exp_tmp);
            rd(ADDR_PSW, {bank, exp_cc});
            rd(ADDR_BANK_ADDR, BANK_BASE_DEFAULT + {5'h0, bank[7:0], 3'h0} + {13'h0, i_gpr_sel});
        end
        // Frozen core ignores both a write and an operation
        @(posedge i_clock);
        i_bus <= '0;
        i_clk_en <= 1'b0;
        wr(ADDR_ACC, 16'hdead);
        alu(OP_ADD8);
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        i_bus <= '0;
        i_alu <= '0;
        rd(ADDR_ACC, exp_acc);
        rd(ADDR_PSW, {bank, exp_cc});
        @(posedge i_clock);
        i_bus <= '0;
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd(ADDR_PSW, 16'h0030);
        rd(ADDR_ACC, 16'h0);
        ip(1'b0, 1'b0, 16'h0);
        ip(1'b0, 1'b0, 16'h0);
        // Let the last pending read be compared before the verdict
        @(posedge i_clock);
        wrap_up();
    end
endmodule : cpu_status_and_register_banks_test
